// ==== sit_target.sv ====
// Two-wire target port: bus engine on the link clock, register access on the system clock
module sit_target (
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic CE,
	input wire logic LINK_CLK,
	input wire logic SCL_I,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE,
	output logic SCL_OE,
	output logic [7:0] REG_ADDR,
	output logic [7:0] REG_WDATA,
	output logic REG_WR,
	output logic REG_RD,
	input wire logic [7:0] REG_RDATA
);
	sit_pkg::sit_link_type lr_reg;
	sit_pkg::sit_link_type lr_next;
	sit_pkg::sit_core_type cr_reg;
	sit_pkg::sit_core_type cr_next;

	logic [1:0] pin_s;
	logic scl_s;
	logic sda_s;
	logic ce_s;
	logic ack_s;
	logic req_s;
	logic scl_rise;
	logic scl_fall;
	logic start_ev;
	logic stop_ev;
	logic valid_p;
	logic wr_p;
	logic held_p;
	logic valid_w;

	// Bus pins come from another domain
	sit_sync #(.WIDTH(2)) u_pin_sync (
		.clk(LINK_CLK),
		.rst_n(RESETN),
		.d({SCL_I, SDA_I}),
		.q(pin_s)
	);

	sit_sync #(.WIDTH(1)) u_ce_sync (
		.clk(LINK_CLK),
		.rst_n(RESETN),
		.d(CE),
		.q(ce_s)
	);

	sit_sync #(.WIDTH(1)) u_ack_sync (
		.clk(LINK_CLK),
		.rst_n(RESETN),
		.d(cr_reg.ack_tog),
		.q(ack_s)
	);

	sit_sync #(.WIDTH(1)) u_req_sync (
		.clk(CLK),
		.rst_n(RESETN),
		.d(lr_reg.req_tog),
		.q(req_s)
	);

	sit_regmap u_map_ptr (
		.addr(lr_reg.ptr),
		.valid(valid_p),
		.writable(wr_p),
		.held(held_p)
	);

	sit_regmap u_map_word (
		.addr(lr_reg.shift),
		.valid(valid_w),
		.writable(),
		.held()
	);

	assign scl_s = pin_s[1];
	assign sda_s = pin_s[0];
	assign scl_rise = scl_s & ~lr_reg.scl_q;
	assign scl_fall = ~scl_s & lr_reg.scl_q;
	assign start_ev = scl_s & lr_reg.scl_q & lr_reg.sda_q & ~sda_s;
	assign stop_ev = scl_s & lr_reg.scl_q & ~lr_reg.sda_q & sda_s;

	// Link domain: bit engine
	always_comb begin
		lr_next = lr_reg;
		if (ce_s) begin
			lr_next.scl_q = scl_s;
			lr_next.sda_q = sda_s;
			lr_next.sda_o = 1'b0;
			lr_next.scl_oe = 1'b0;
			if (ack_s != lr_reg.ack_seen) begin
				lr_next.ack_seen = ack_s;
				lr_next.rbuf = cr_reg.rdata;
			end
			// Fetch one cycle after the pointer settles so the lookup sees its new value
			if (lr_reg.fetch_pend) begin
				lr_next.fetch_pend = 1'b0;
				lr_next.cmd = '{wr: 1'b0, valid: valid_p, addr: lr_reg.ptr, data: 8'h00};
				lr_next.req_tog = ~lr_reg.req_tog;
			end
			if (start_ev) begin
				// Repeated start lands here too, from any state
				lr_next.state = sit_pkg::LS_ADDR;
				lr_next.bitcnt = 4'h0;
				lr_next.sda_oe = 1'b0;
			end else if (stop_ev) begin
				lr_next.state = sit_pkg::LS_IDLE;
				lr_next.sda_oe = 1'b0;
			end else begin
				case (lr_reg.state)
					sit_pkg::LS_ADDR, sit_pkg::LS_WORD, sit_pkg::LS_WDATA: begin
						if (scl_rise && lr_reg.bitcnt != sit_pkg::BYTE_BITS) begin
							lr_next.shift = {lr_reg.shift[6:0], sda_s};
							lr_next.bitcnt = lr_reg.bitcnt + 4'h1;
						end else if (scl_fall && lr_reg.bitcnt == sit_pkg::BYTE_BITS) begin
							lr_next.bitcnt = 4'h0;
							if (lr_reg.state == sit_pkg::LS_ADDR) begin
								if (lr_reg.shift[7:1] == sit_pkg::TARGET_ADDR) begin
									lr_next.rw = lr_reg.shift[0];
									lr_next.sda_oe = 1'b1;
									lr_next.fetch_pend = lr_reg.shift[0];
									lr_next.state = sit_pkg::LS_ADDR_ACK;
								end else begin
									lr_next.state = sit_pkg::LS_IDLE;
								end
							end else if (lr_reg.state == sit_pkg::LS_WORD) begin
								lr_next.ptr = lr_reg.shift;
								lr_next.sda_oe = valid_w;
								lr_next.state = sit_pkg::LS_WORD_ACK;
							end else begin
								lr_next.sda_oe = wr_p;
								lr_next.ptr = lr_reg.ptr + sit_pkg::PTR_STEP;
								lr_next.state = sit_pkg::LS_WDATA_ACK;
								if (wr_p) begin
									lr_next.cmd = '{wr: 1'b1, valid: 1'b1, addr: lr_reg.ptr, data: lr_reg.shift};
									lr_next.req_tog = ~lr_reg.req_tog;
								end
							end
						end
					end
					sit_pkg::LS_ADDR_ACK, sit_pkg::LS_WORD_ACK, sit_pkg::LS_WDATA_ACK: begin
						// Held until the falling edge, so low across the whole high phase
						if (scl_fall) begin
							lr_next.sda_oe = 1'b0;
							if (lr_reg.state == sit_pkg::LS_ADDR_ACK && lr_reg.rw) begin
								lr_next.shift = lr_reg.rbuf;
								lr_next.sda_oe = ~lr_reg.rbuf[7];
								lr_next.state = sit_pkg::LS_RDATA;
							end else if (lr_reg.state == sit_pkg::LS_ADDR_ACK) begin
								lr_next.state = sit_pkg::LS_WORD;
							end else begin
								lr_next.state = sit_pkg::LS_WDATA;
							end
						end
					end
					sit_pkg::LS_RDATA: begin
						if (scl_rise && lr_reg.bitcnt != sit_pkg::BYTE_BITS) begin
							lr_next.bitcnt = lr_reg.bitcnt + 4'h1;
						end else if (scl_fall) begin
							if (lr_reg.bitcnt == sit_pkg::BYTE_BITS) begin
								lr_next.bitcnt = 4'h0;
								lr_next.sda_oe = 1'b0;
								lr_next.fetch_pend = 1'b1;
								lr_next.state = sit_pkg::LS_RDATA_ACK;
								if (!held_p) begin
									lr_next.ptr = lr_reg.ptr + sit_pkg::PTR_STEP;
								end
							end else begin
								// Next bit goes out only while SCL is low
								lr_next.shift = {lr_reg.shift[6:0], 1'b0};
								lr_next.sda_oe = ~lr_reg.shift[6];
							end
						end
					end
					sit_pkg::LS_RDATA_ACK: begin
						if (scl_rise) begin
							lr_next.nack = sda_s;
						end else if (scl_fall) begin
							if (lr_reg.nack) begin
								lr_next.state = sit_pkg::LS_WAIT;
							end else begin
								lr_next.shift = lr_reg.rbuf;
								lr_next.sda_oe = ~lr_reg.rbuf[7];
								lr_next.state = sit_pkg::LS_RDATA;
							end
						end
					end
					default: begin
						lr_next.sda_oe = 1'b0;
					end
				endcase
			end
		end
	end

	always_ff @(posedge LINK_CLK or negedge RESETN) begin
		if (!RESETN) begin
			lr_reg <= '{state: sit_pkg::LS_IDLE, scl_q: 1'b1, sda_q: 1'b1, ptr: sit_pkg::PTR_RESET, default: '0};
		end else begin
			lr_reg <= lr_next;
		end
	end

	// System domain: register access, command word is stable while the toggle is in flight
	always_comb begin
		cr_next = cr_reg;
		if (CE) begin
			cr_next.reg_wr = 1'b0;
			cr_next.reg_rd = 1'b0;
			case (cr_reg.state)
				sit_pkg::CS_IDLE: begin
					if (req_s != cr_reg.req_seen) begin
						cr_next.req_seen = req_s;
						cr_next.addr = lr_reg.cmd.addr;
						cr_next.wdata = lr_reg.cmd.data;
						cr_next.reg_wr = lr_reg.cmd.wr;
						cr_next.reg_rd = ~lr_reg.cmd.wr & lr_reg.cmd.valid;
						cr_next.rd_valid = ~lr_reg.cmd.wr & lr_reg.cmd.valid;
						cr_next.state = sit_pkg::CS_PULSE;
					end
				end
				sit_pkg::CS_PULSE: begin
					cr_next.state = sit_pkg::CS_CAP;
				end
				default: begin
					cr_next.rdata = cr_reg.rd_valid ? REG_RDATA : 8'h00;
					cr_next.ack_tog = ~cr_reg.ack_tog;
					cr_next.state = sit_pkg::CS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			cr_reg <= '{state: sit_pkg::CS_IDLE, default: '0};
		end else begin
			cr_reg <= cr_next;
		end
	end

	assign SDA_O = lr_reg.sda_o;
	assign SDA_OE = lr_reg.sda_oe;
	assign SCL_OE = lr_reg.scl_oe;
	assign REG_ADDR = cr_reg.addr;
	assign REG_WDATA = cr_reg.wdata;
	assign REG_WR = cr_reg.reg_wr;
	assign REG_RD = cr_reg.reg_rd;

	logic recv_end;
	logic is_ack;
	assign recv_end = ce_s && !start_ev && !stop_ev && scl_fall && lr_reg.bitcnt == sit_pkg::BYTE_BITS;
	assign is_ack = lr_reg.state == sit_pkg::LS_ADDR_ACK || lr_reg.state == sit_pkg::LS_WORD_ACK
		|| lr_reg.state == sit_pkg::LS_WDATA_ACK;

	property p_addr_miss;
		@(posedge LINK_CLK) disable iff (!RESETN)
		(recv_end && lr_reg.state == sit_pkg::LS_ADDR && lr_reg.shift[7:1] != sit_pkg::TARGET_ADDR)
		|=> (lr_reg.state == sit_pkg::LS_IDLE && !SDA_OE);
	endproperty
	a_addr_miss: assert property (p_addr_miss) else $error("foreign address answered");

	property p_addr_hit;
		@(posedge LINK_CLK) disable iff (!RESETN)
		(recv_end && lr_reg.state == sit_pkg::LS_ADDR && lr_reg.shift[7:1] == sit_pkg::TARGET_ADDR)
		|=> (SDA_OE && lr_reg.state == sit_pkg::LS_ADDR_ACK && lr_reg.rw == $past(lr_reg.shift[0]));
	endproperty
	a_addr_hit: assert property (p_addr_hit) else $error("own address not acknowledged");

	property p_word_load;
		@(posedge LINK_CLK) disable iff (!RESETN)
		(recv_end && lr_reg.state == sit_pkg::LS_WORD) |=> (lr_reg.ptr == $past(lr_reg.shift) && SDA_OE == $past(valid_w));
	endproperty
	a_word_load: assert property (p_word_load) else $error("word address not loaded or answered wrongly");

	property p_wr_step;
		@(posedge LINK_CLK) disable iff (!RESETN)
		(recv_end && lr_reg.state == sit_pkg::LS_WDATA)
		|=> (lr_reg.ptr == $past(lr_reg.ptr) + sit_pkg::PTR_STEP && SDA_OE == $past(wr_p));
	endproperty
	a_wr_step: assert property (p_wr_step) else $error("write pointer step or answer wrong");

	property p_rd_hold;
		@(posedge LINK_CLK) disable iff (!RESETN)
		(recv_end && lr_reg.state == sit_pkg::LS_RDATA)
		|=> (lr_reg.ptr == ($past(held_p) ? $past(lr_reg.ptr) : $past(lr_reg.ptr) + sit_pkg::PTR_STEP));
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read pointer hold or step wrong");

	property p_ack_steady;
		@(posedge LINK_CLK) disable iff (!RESETN)
		(is_ack && SDA_OE && scl_s && lr_reg.scl_q && !start_ev && !stop_ev) |=> SDA_OE;
	endproperty
	a_ack_steady: assert property (p_ack_steady) else $error("acknowledge dropped in high phase");

	property p_nack_release;
		@(posedge LINK_CLK) disable iff (!RESETN)
		(ce_s && lr_reg.state == sit_pkg::LS_RDATA_ACK && lr_reg.nack && scl_fall && !start_ev && !stop_ev)
		|=> (!SDA_OE && lr_reg.state == sit_pkg::LS_WAIT) [*2];
	endproperty
	a_nack_release: assert property (p_nack_release) else $error("SDA not released after final nack");

	property p_no_stretch;
		@(posedge LINK_CLK) disable iff (!RESETN)
		1'b1 |-> !SCL_OE;
	endproperty
	a_no_stretch: assert property (p_no_stretch) else $error("SCL driven");

	property p_wr_pulse;
		@(posedge CLK) disable iff (!RESETN)
		REG_WR |-> (!REG_RD ##1 !REG_WR);
	endproperty
	a_wr_pulse: assert property (p_wr_pulse) else $error("store strobe longer than a cycle");

	property p_rd_zero;
		@(posedge CLK) disable iff (!RESETN)
		(CE && cr_reg.state == sit_pkg::CS_CAP && !cr_reg.rd_valid) |=> (cr_reg.rdata == 8'h00);
	endproperty
	a_rd_zero: assert property (p_rd_zero) else $error("invalid read not zero");

	property p_cov_write;
		@(posedge LINK_CLK) disable iff (!RESETN)
		recv_end && lr_reg.state == sit_pkg::LS_WDATA && wr_p;
	endproperty
	c_cov_write: cover property (p_cov_write);

	property p_cov_read_end;
		@(posedge LINK_CLK) disable iff (!RESETN)
		lr_reg.state == sit_pkg::LS_RDATA_ACK ##1 lr_reg.state == sit_pkg::LS_WAIT;
	endproperty
	c_cov_read_end: cover property (p_cov_read_end);

	property p_cov_restart;
		@(posedge LINK_CLK) disable iff (!RESETN)
		ce_s && start_ev && lr_reg.state == sit_pkg::LS_WDATA;
	endproperty
	c_cov_restart: cover property (p_cov_restart);
endmodule : sit_target

// ==== sit_pkg.sv ====
// Constants and types of the sensor two-wire target port
// Summary of operation
// - Only a first byte carrying the fixed target address selects this port.
// - First byte after an acknowledged write address loads the pointer.
// - Pointer advances after each data byte: always on writes, on reads unless held.
// - An invalid word address is not acknowledged; the transfer goes on.
// - Reads from an invalid address return zero and still advance the pointer.
// - Sequential reads cover the whole range and wrap past the top.
// - Reads of the angle, raw angle and magnitude registers hold the pointer.
// - The hold applies only when the pointer sits on the high byte.
// - Writes to an invalid register are dropped, not acknowledged, pointer advances.
// - Once the pointer is writable again, written bytes are acknowledged and stored.
// - Page writes cover the whole range and wrap past the top.
// - SDA falling with SCL high is start; SDA rising with SCL high is stop.
// - SDA changes only while SCL is low; one bit per clock period.
// - Bytes are followed by a ninth clock in which the receiver answers.
// - Every byte travels most significant bit first.
// - Transfer length is set by the controller alone.
// - An acknowledge holds SDA low through the whole high phase.
// - After the controller's final not-acknowledge, SDA is released.
// - Direction bit 0 is write, 1 is read; a matching address is acknowledged.
// - Reads start at the pointer as last stored.
// - SCL is never held low by this port.
// - Incoming SDA bits are sampled on the rising SCL edge.
package sit_pkg;
	localparam logic [6:0] TARGET_ADDR = 7'h36;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [7:0] PTR_STEP = 8'h01;
	localparam logic [7:0] PTR_RESET = 8'h00;
	localparam logic [7:0] A_CFG_LO = 8'h00;
	localparam logic [7:0] A_ZERO_LO = 8'h01;
	localparam logic [7:0] A_ZERO_HI = 8'h02;
	localparam logic [7:0] A_CONF_LO = 8'h07;
	localparam logic [7:0] A_CONF_HI = 8'h0A;
	localparam logic [7:0] A_OUT_LO = 8'h0B;
	localparam logic [7:0] A_OUT_HI = 8'h0F;
	localparam logic [7:0] A_MAG_LO = 8'h1A;
	localparam logic [7:0] A_MAG_HI = 8'h1C;
	localparam logic [7:0] A_BURN = 8'hFF;
	localparam logic [7:0] A_RAW_HOLD = 8'h0C;
	localparam logic [7:0] A_ANG_HOLD = 8'h0E;
	localparam logic [7:0] A_MAG_HOLD = 8'h1B;

	typedef enum logic [3:0] {
		LS_IDLE, LS_ADDR, LS_ADDR_ACK, LS_WORD, LS_WORD_ACK,
		LS_WDATA, LS_WDATA_ACK, LS_RDATA, LS_RDATA_ACK, LS_WAIT
	} sit_lstate_type;

	typedef enum logic [1:0] {CS_IDLE, CS_PULSE, CS_CAP} sit_cstate_type;

	typedef struct packed {
		logic wr;
		logic valid;
		logic [7:0] addr;
		logic [7:0] data;
	} sit_cmd_type;

	typedef struct packed {
		sit_lstate_type state;
		logic scl_q;
		logic sda_q;
		logic [3:0] bitcnt;
		logic [7:0] shift;
		logic rw;
		logic nack;
		logic [7:0] ptr;
		logic sda_oe;
		logic sda_o;
		logic scl_oe;
		logic fetch_pend;
		logic req_tog;
		sit_cmd_type cmd;
		logic ack_seen;
		logic [7:0] rbuf;
	} sit_link_type;

	typedef struct packed {
		sit_cstate_type state;
		logic req_seen;
		logic rd_valid;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic reg_wr;
		logic reg_rd;
		logic [7:0] rdata;
		logic ack_tog;
	} sit_core_type;
endpackage : sit_pkg

// ==== sit_sync.sv ====
// Three-stage synchroniser that passes a bit once stages two and three agree
module sit_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] q;
	} sit_sync_type;

	sit_sync_type r_reg;
	sit_sync_type r_next;

	always_comb begin
		r_next = r_reg;
		r_next.s1 = d;
		r_next.s2 = r_reg.s1;
		r_next.s3 = r_reg.s2;
		// Disagreeing bits keep their last agreed value
		r_next.q = (r_reg.s2 & ~(r_reg.s2 ^ r_reg.s3)) | (r_reg.q & (r_reg.s2 ^ r_reg.s3));
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign q = r_reg.q;
endmodule : sit_sync

// ==== sit_regmap.sv ====
// Address classification: present, writable, and held on reads
module sit_regmap (
	input wire logic [7:0] addr,
	output logic valid,
	output logic writable,
	output logic held
);
	always_comb begin
		valid = 1'b0;
		writable = 1'b0;
		held = 1'b0;
		if (addr <= sit_pkg::A_ZERO_HI) begin
			valid = 1'b1;
			writable = (addr >= sit_pkg::A_ZERO_LO);
		end else if (addr >= sit_pkg::A_CONF_LO && addr <= sit_pkg::A_CONF_HI) begin
			valid = 1'b1;
			writable = 1'b1;
		end else if (addr >= sit_pkg::A_OUT_LO && addr <= sit_pkg::A_OUT_HI) begin
			valid = 1'b1;
		end else if (addr >= sit_pkg::A_MAG_LO && addr <= sit_pkg::A_MAG_HI) begin
			valid = 1'b1;
		end else if (addr == sit_pkg::A_BURN) begin
			valid = 1'b1;
			writable = 1'b1;
		end
		// Only the high byte holds, so a read started on the low byte still walks on
		held = (addr == sit_pkg::A_RAW_HOLD) || (addr == sit_pkg::A_ANG_HOLD) || (addr == sit_pkg::A_MAG_HOLD);
	end
endmodule : sit_regmap

// ==== sit_ctl_model.sv ====
// Bus controller model that drives clock and data towards the target port
module sit_ctl_model (
	input wire logic clk,
	input wire logic sda,
	output logic scl,
	output logic sda_oe,
	output logic res_v,
	output logic [8:0] res
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		scl = 1'b1;
		sda_oe = 1'b0;
		res_v = 1'b0;
		res = 9'h000;
	end
	task automatic wt(input int n);
		repeat (n) @(negedge clk);
	endtask : wt
	// Data moves only in the low phase; sampled mid high phase
	task automatic bit_x(input logic b, output logic s);
		sda_oe = ~b;
		wt(30);
		scl = 1'b1;
		wt(20);
		s = sda;
		wt(20);
		scl = 1'b0;
		wt(30);
	endtask : bit_x
	// Also serves as repeated start when the clock is low
	task automatic start();
		sda_oe = 1'b0;
		wt(30);
		scl = 1'b1;
		wt(30);
		sda_oe = 1'b1;
		wt(30);
		scl = 1'b0;
		wt(30);
	endtask : start
	task automatic stop();
		sda_oe = 1'b1;
		wt(30);
		scl = 1'b1;
		wt(30);
		sda_oe = 1'b0;
		wt(60);
	endtask : stop
	task automatic note(input logic [8:0] r);
		res = r;
		res_v = 1'b1;
		wt(1);
		res_v = 1'b0;
	endtask : note
	task automatic wr(input logic [7:0] b);
		logic a;
		for (int i = 7; i >= 0; i--) bit_x(b[i], a);
		bit_x(1'b1, a);
		note({a, b});
	endtask : wr
	// Length of a read is chosen by the caller alone
	task automatic rd(input logic nak);
		logic [7:0] d;
		logic s;
		for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
		bit_x(nak, s);
		note({nak, d});
	endtask : rd
endmodule : sit_ctl_model

// ==== tb_top.sv ====
// Self-checking testbench of the two-wire target port
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic lclk = 1'b0;
	logic rstn = 1'b0;
	logic rd_d = 1'b0;
	logic ce = 1'b1;
	logic sda_oe, scl_oe, sda_o, wr, rd, scl, c_oe, res_v;
	logic [7:0] addr, wdata, rdata, ptr;
	logic [8:0] res;
	logic [7:0] hold[3] = '{8'h0C, 8'h0E, 8'h1B};
	logic [16:0] reg_q[$];
	logic [16:0] bus_q[$];
	int n_mismatch = 0;
	int checks_done = 0;
	int cyc = 0;
	int seed = 32'h1897_c5d0;
	// Open drain with pull-up
	wire sda = ~(c_oe | sda_oe);
	always #5 clk = ~clk;
	initial begin
		#3.7;
		forever #6 lclk = ~lclk;
	end
	sit_target i_dut (.CLK(clk), .RESETN(rstn), .CE(ce), .LINK_CLK(lclk), .SCL_I(scl & ~scl_oe), .SDA_I(sda),
		.SDA_O(sda_o), .SDA_OE(sda_oe), .SCL_OE(scl_oe), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
		.REG_RD(rd), .REG_RDATA(rdata));
	sit_ctl_model i_ctl (.clk(clk), .sda(sda), .scl(scl), .sda_oe(c_oe), .res_v(res_v), .res(res));
	// Register side: garbage except from mid read strobe through mid of the cycle after it
	always @(negedge clk) begin
		rd_d <= rd;
		rdata <= (rd | rd_d) ? addr ^ 8'hA5 : 8'($random(seed));
	end
	function automatic bit vld(input logic [7:0] a);
		return a <= 8'h02 || (a >= 8'h07 && a <= 8'h0F) || (a >= 8'h1A && a <= 8'h1C) || a == 8'hFF;
	endfunction : vld
	function automatic bit wrb(input logic [7:0] a);
		return (a >= 8'h01 && a <= 8'h02) || (a >= 8'h07 && a <= 8'h0A) || a == 8'hFF;
	endfunction : wrb
	function automatic bit hld(input logic [7:0] a);
		return a == 8'h0C || a == 8'h0E || a == 8'h1B;
	endfunction : hld
	task automatic check(input logic [16:0] seen, input logic [16:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : end_of_test
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask : done
	// Strobes sampled mid-cycle, clear of the edge that launches them
	always @(negedge clk) begin
		if (wr === 1'b1 || rd === 1'b1) check({wr, addr, wr ? wdata : 8'h00}, reg_q.size() ? reg_q.pop_front() : 17'bx);
	end
	always @(posedge clk) begin
		if (res_v) check({8'h00, res}, bus_q.size() ? bus_q.pop_front() : 17'bx);
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			n_mismatch++;
			end_of_test();
		end
	end
	task automatic wb(input logic [7:0] b, input logic nak);
		bus_q.push_back({8'h00, nak, b});
		i_ctl.wr(b);
	endtask : wb
	task automatic wr_run(input logic [7:0] p, input int n, input bit rs);
		logic [7:0] d;
		i_ctl.start();
		wb(8'h6C, 1'b0);
		wb(p, !vld(p));
		ptr = p;
		repeat (n) begin
			d = 8'($random(seed));
			if (wrb(ptr)) reg_q.push_back({1'b1, ptr, d});
			wb(d, !wrb(ptr));
			ptr++;
		end
		if (!rs) i_ctl.stop();
	endtask : wr_run
	// Fetches may start in the address ack, so all notes go in first
	task automatic rd_run(input int n);
		logic [7:0] a;
		a = ptr;
		bus_q.push_back(17'h0_006D);
		for (int i = 0; i < n; i++) begin
			if (vld(a)) reg_q.push_back({1'b0, a, 8'h00});
			bus_q.push_back({8'h00, i == n - 1, vld(a) ? a ^ 8'hA5 : 8'h00});
			if (!hld(a)) a++;
		end
		// Port fetches one byte ahead, so the last byte also reads the next register
		if (vld(a)) reg_q.push_back({1'b0, a, 8'h00});
		i_ctl.start();
		i_ctl.wr(8'h6D);
		for (int i = 0; i < n; i++) i_ctl.rd(i == n - 1);
		check({15'h0000, sda_o, sda_oe}, 17'h0_0000);
		i_ctl.stop();
		ptr = a;
	endtask : rd_run
	initial begin
		repeat (2) @(negedge clk);
		rstn = 1'b1;
		check({sda_oe, scl_oe, wr, rd, sda_o, wdata[3:0], addr}, 17'h0_0000);
		repeat (20) @(negedge clk);
		i_ctl.start();
		wb(8'h6E, 1'b1);
		i_ctl.stop();
		done("foreign address");
		// Frozen port ignores a whole transfer, own address included
		ce = 1'b0;
		repeat (10) @(negedge clk);
		i_ctl.start();
		wb(8'h6C, 1'b1);
		wb(8'h01, 1'b1);
		i_ctl.stop();
		ce = 1'b1;
		repeat (10) @(negedge clk);
		done("clock enable");
		wr_run(8'h09, 3, 1'b0);
		wr_run(8'h03, 5, 1'b0);
		wr_run(8'hFE, 4, 1'b0);
		done("writes");
		wr_run(8'hFE, 0, 1'b1);
		rd_run(3);
		foreach (hold[i]) begin
			wr_run(hold[i], 0, 1'b1);
			rd_run(3);
		end
		wr_run(8'h0D, 0, 1'b1);
		rd_run(3);
		rd_run(2);
		done("reads");
		repeat (50) @(negedge clk);
		check(17'(reg_q.size()), 17'h0_0000);
		check(17'(bus_q.size()), 17'h0_0000);
		end_of_test();
	end
endmodule : tb_top
